// *** inc/dspmb_map.svh ***
// Register map, field positions and fixed widths of the multiply-add block
// What this block does
// - Each half configured into one operating mode
// - Two halves, four 18x18 multipliers each
// - Halves may run different modes simultaneously
// - Halves share only four clock/enable/clear groups
// - Loopback uses two multipliers per half
// - Shift mode: arithmetic, logical shifts, rotation
// - Shift acts on 32-bit vector, zero-extended into 56-bit lane
// - High precision: 18x36 products, add only
`ifndef DSPMB_MAP_SVH
`define DSPMB_MAP_SVH
`define DSPMB_LANE_W 56
`define DSPMB_ADR_W 9
`define DSPMB_HALF_STRIDE 9'h080
`define DSPMB_OFF_CTRL 7'h00
`define DSPMB_OFF_A0 7'h10
`define DSPMB_OFF_B0 7'h20
`define DSPMB_OFF_RESL0 7'h40
`define DSPMB_OFF_RESH0 7'h50
`define DSPMB_ADR_CLKCTL 9'h100
`define DSPMB_CTRL_RST 11'h000
`define DSPMB_CTRL_MODE_LSB 0
`define DSPMB_CTRL_SGN_BIT 3
`define DSPMB_CTRL_SUB_BIT 4
`define DSPMB_CTRL_LPBK_BIT 5
`define DSPMB_CTRL_SHOP_LSB 6
`define DSPMB_CTRL_GRP_LSB 9
`define DSPMB_ENA_RST 4'hf
`define DSPMB_CLKCTL_CLR_LSB 4
`define DSPMB_SUM36_W 36
`endif

// *** inc/dspmb_pkg.sv ***
// Types shared by the multiply-add block modules
package dspmb_pkg;
    // Operating mode of one half, one-hot
    typedef enum logic [5:0] {
        DSPMB_INDEP  = 6'h01,
        DSPMB_ADD2   = 6'h02,
        DSPMB_ADD4   = 6'h04,
        DSPMB_HIPREC = 6'h08,
        DSPMB_MAC    = 6'h10,
        DSPMB_SHIFT  = 6'h20
    } dspmb_mode_e;
    // Shift operation code as written by software
    typedef enum logic [2:0] {
        DSPMB_ASL = 3'h0,
        DSPMB_ASR = 3'h1,
        DSPMB_LSL = 3'h2,
        DSPMB_LSR = 3'h3,
        DSPMB_ROT = 3'h4
    } dspmb_shop_e;
endpackage

// *** inc/dspmb_half_if.sv ***
// Connection between the register front end and one arithmetic half
`timescale 1ns/1ps
`include "dspmb_map.svh"
interface dspmb_half_if;
    import dspmb_pkg::*;
    dspmb_mode_e mode; // Operating mode
    logic sgn; // Signed operands
    logic sub; // First stage subtracts
    logic lpbk; // Loopback on multiplier 0
    dspmb_shop_e shop; // Shift operation
    logic [31:0] a [4]; // Operand A words
    logic [17:0] b [4]; // Operand B words
    logic en; // Selected group enable
    logic clr; // Selected group clear
    logic [`DSPMB_LANE_W-1:0] res [4]; // Result lanes
    modport front (output mode, sgn, sub, lpbk, shop, a, b, en, clr, input res);
    modport half (input mode, sgn, sub, lpbk, shop, a, b, en, clr, output res);
endinterface

// *** logic/dspmb_half.sv ***
// One arithmetic half: four 18x18 multipliers, adders, accumulator, shifter
`timescale 1ns/1ps
`include "dspmb_map.svh"
module dspmb_half (
    input wire logic clk_i,
    input wire logic rst_i,
    dspmb_half_if.half hif
);
    import dspmb_pkg::*;
    localparam int W = `DSPMB_LANE_W;
    localparam logic [W-1:0] MASK36 = {{(W-`DSPMB_SUM36_W){1'b0}}, {`DSPMB_SUM36_W{1'b1}}};

    logic [W-1:0] res [4]; // Result registers
    logic [W-1:0] next_res [4]; // Their next values
    logic [W-1:0] p [4]; // Plain products
    logic [W-1:0] lp0; // Product with fed-back operand
    logic [W-1:0] hp0; // Wide product, lanes 0/1
    logic [W-1:0] hp1; // Wide product, lanes 2/3

    // Widen an 18-bit operand, sign-extending only when signed
    function automatic logic [35:0] ext18(input logic [17:0] x, input logic s);
        ext18 = {{18{s & x[17]}}, x};
    endfunction

    // Multiply two 36-bit operands, result cut to lane width
    function automatic logic [W-1:0] mulx(input logic [35:0] x, input logic [35:0] y,
                                          input logic s);
        logic signed [73:0] prod;
        prod = $signed({s & x[35], x}) * $signed({s & y[35], y});
        mulx = prod[W-1:0];
    endfunction

    // Add or subtract a pair depending on first stage setting
    function automatic logic [W-1:0] pair(input logic [W-1:0] x, input logic [W-1:0] y,
                                          input logic s);
        pair = s ? x - y : x + y;
    endfunction

    // Barrel shifter for the 32-bit vector
    function automatic logic [31:0] shf(input logic [31:0] x, input logic [4:0] n,
                                        input dspmb_shop_e op);
        logic [63:0] dbl;
        dbl = {x, x} << n;
        unique case (op)
            DSPMB_ASL: shf = x <<< n;
            DSPMB_ASR: shf = 32'($signed(x) >>> n);
            DSPMB_LSL: shf = x << n;
            DSPMB_LSR: shf = x >> n;
            default: shf = dbl[63:32]; // Rotation left
        endcase
    endfunction

    // Multipliers and next result
    always_comb
    begin
        for (int k = 0; k < 4; k++)
        begin
            p[k] = mulx(ext18(hif.a[k][17:0], hif.sgn), ext18(hif.b[k], hif.sgn), hif.sgn);
        end
        lp0 = mulx(ext18(res[0][17:0], hif.sgn), ext18(hif.b[0], hif.sgn), hif.sgn);
        hp0 = mulx(ext18(hif.a[0][17:0], hif.sgn), {hif.b[1], hif.b[0]}, hif.sgn);
        hp1 = mulx(ext18(hif.a[2][17:0], hif.sgn), {hif.b[3], hif.b[2]}, hif.sgn);
        next_res = res;
        if (hif.clr)
        begin
            // Clear wins over enable
            for (int k = 0; k < 4; k++)
            begin
                next_res[k] = '0;
            end
        end
        else if (hif.en)
        begin
            for (int k = 1; k < 4; k++)
            begin
                next_res[k] = '0;
            end
            unique case (hif.mode)
                DSPMB_INDEP:
                begin
                    for (int k = 0; k < 4; k++)
                    begin
                        next_res[k] = p[k];
                    end
                end
                DSPMB_ADD2:
                begin
                    // Sums kept to 36 bits; the driver keeps unsigned ones in range
                    next_res[0] = pair(hif.lpbk ? lp0 : p[0], p[1], hif.sub) & MASK36;
                    next_res[1] = pair(p[2], p[3], hif.sub) & MASK36;
                end
                DSPMB_ADD4: next_res[0] = pair(p[0], p[1], hif.sub) + pair(p[2], p[3], hif.sub);
                DSPMB_HIPREC: next_res[0] = hp0 + hp1;
                DSPMB_MAC:
                    next_res[0] = res[0] + pair(p[0], p[1], hif.sub) + pair(p[2], p[3], hif.sub);
                DSPMB_SHIFT:
                    next_res[0] = {{(W-32){1'b0}}, shf(hif.a[0], hif.b[0][4:0], hif.shop)};
            endcase
        end
    end

    // Result registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int k = 0; k < 4; k++)
            begin
                res[k] <= '0;
            end
        end
        else
        begin
            res <= next_res;
        end
    end

    assign hif.res = res;

    // Checks
    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        !hif.en && !hif.clr |=> res[0] == $past(res[0]) && res[3] == $past(res[3]);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved without enable");
    property p_clr;
        @(posedge clk_i) disable iff (rst_i)
        hif.clr |=> res[0] == '0 && res[1] == '0 && res[2] == '0 && res[3] == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear did not zero results");
    property p_indep;
        @(posedge clk_i) disable iff (rst_i)
        hif.en && !hif.clr && hif.mode == DSPMB_INDEP |=> res[3] == $past(p[3]);
    endproperty
    a_indep: assert property (p_indep) else $error("fourth multiplier wrong");
    property p_rot0;
        @(posedge clk_i) disable iff (rst_i)
        hif.en && !hif.clr && hif.mode == DSPMB_SHIFT && hif.shop == DSPMB_ROT
            && hif.b[0][4:0] == 5'h00 |=> res[0][31:0] == $past(hif.a[0]);
    endproperty
    a_rot0: assert property (p_rot0) else $error("zero rotation altered vector");
    property p_sh32;
        @(posedge clk_i) disable iff (rst_i)
        hif.en && !hif.clr && hif.mode == DSPMB_SHIFT |=> res[0][W-1:32] == '0 && res[1] == '0;
    endproperty
    a_sh32: assert property (p_sh32) else $error("shift result wider than 32 bits");
    property p_add2;
        @(posedge clk_i) disable iff (rst_i)
        hif.en && !hif.clr && hif.mode == DSPMB_ADD2
            |=> res[0][W-1:36] == '0 && res[1][W-1:36] == '0 && res[2] == '0;
    endproperty
    a_add2: assert property (p_add2) else $error("two-multiplier sum exceeds 36 bits");
    property p_hip;
        @(posedge clk_i) disable iff (rst_i)
        hif.en && !hif.clr && hif.mode == DSPMB_HIPREC
            |=> res[0] == $past(hp0) + $past(hp1);
    endproperty
    a_hip: assert property (p_hip) else $error("wide products not added");
    property p_loop;
        @(posedge clk_i) disable iff (rst_i)
        hif.en && !hif.clr && hif.mode == DSPMB_ADD2 && hif.lpbk
            |=> res[1] == (pair($past(p[2]), $past(p[3]), $past(hif.sub)) & MASK36);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback disturbed other adder");
    c_mac: cover property (@(posedge clk_i) disable iff (rst_i)
        hif.en && hif.mode == DSPMB_MAC [*3]);
    c_shift: cover property (@(posedge clk_i) disable iff (rst_i)
        hif.en && hif.mode == DSPMB_SHIFT && hif.shop == DSPMB_ASR);
    c_loop: cover property (@(posedge clk_i) disable iff (rst_i)
        hif.en && hif.mode == DSPMB_ADD2 && hif.lpbk ##1 hif.en);
endmodule

// *** logic/dspmb_top.sv ***
// Wishbone front end and two independent multiply-add halves
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "dspmb_map.svh"
module dspmb_top #(
    parameter int ADR_W = `DSPMB_ADR_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import dspmb_pkg::*;
    localparam int W = `DSPMB_LANE_W;

    logic [10:0] ctrl [2]; // Per-half control words
    logic [10:0] next_ctrl [2];
    logic [31:0] opa [2][4]; // Operand A words
    logic [31:0] next_opa [2][4];
    logic [17:0] opb [2][4]; // Operand B words
    logic [17:0] next_opb [2][4];
    logic [3:0] ena; // Shared enable groups
    logic [3:0] next_ena;
    logic [3:0] clr; // Shared clear pulses
    logic [3:0] next_clr;
    logic ack; // Bus acknowledge
    logic next_ack;
    logic [31:0] rdat; // Registered read data
    logic [31:0] next_rdat;
    logic req; // New bus request this cycle
    logic hsel; // Half select from address
    logic inhalf; // Address lies in a half window
    logic [6:0] off; // Offset inside the half window
    dspmb_half_if hif [2] ();

    // Apply byte enables to a word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int i = 0; i < 4; i++)
        begin
            merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // Map the written mode code to a one-hot mode; unused codes fall back
    function automatic dspmb_mode_e mode_of(input logic [2:0] code);
        unique case (code)
            3'h1: mode_of = DSPMB_ADD2;
            3'h2: mode_of = DSPMB_ADD4;
            3'h3: mode_of = DSPMB_HIPREC;
            3'h4: mode_of = DSPMB_MAC;
            3'h5: mode_of = DSPMB_SHIFT;
            default: mode_of = DSPMB_INDEP;
        endcase
    endfunction

    // Map the written shift code; unused codes rotate
    function automatic dspmb_shop_e shop_of(input logic [2:0] code);
        shop_of = code > 3'h4 ? DSPMB_ROT : dspmb_shop_e'(code);
    endfunction

    // Address decode shared by reads and writes
    always_comb
    begin
        req = wb_cyc_i && wb_stb_i && !ack;
        inhalf = wb_adr_i[8] == 1'b0;
        hsel = wb_adr_i[7];
        off = wb_adr_i[6:0];
    end

    // Each half draws its enable and clear from one shared group
    for (genvar h = 0; h < 2; h++)
    begin : g_half
        logic [1:0] grp; // Chosen clock group
        assign grp = ctrl[h][`DSPMB_CTRL_GRP_LSB +: 2];
        assign hif[h].mode = mode_of(ctrl[h][`DSPMB_CTRL_MODE_LSB +: 3]);
        assign hif[h].sgn = ctrl[h][`DSPMB_CTRL_SGN_BIT];
        assign hif[h].sub = ctrl[h][`DSPMB_CTRL_SUB_BIT];
        assign hif[h].lpbk = ctrl[h][`DSPMB_CTRL_LPBK_BIT];
        assign hif[h].shop = shop_of(ctrl[h][`DSPMB_CTRL_SHOP_LSB +: 3]);
        assign hif[h].a = opa[h];
        assign hif[h].b = opb[h];
        assign hif[h].en = ena[grp];
        assign hif[h].clr = clr[grp];
        dspmb_half u_half (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .hif(hif[h])
        );
    end

    // Next configuration from bus writes
    always_comb
    begin
        next_ctrl = ctrl;
        next_opa = opa;
        next_opb = opb;
        next_ena = ena;
        next_clr = 4'h0; // Clears last one cycle
        if (req && wb_we_i)
        begin
            if (wb_adr_i == `DSPMB_ADR_CLKCTL)
            begin
                if (wb_sel_i[0])
                begin
                    next_ena = wb_dat_i[3:0];
                    next_clr = wb_dat_i[`DSPMB_CLKCTL_CLR_LSB +: 4];
                end
            end
            else if (inhalf)
            begin
                // Writes touch one half only
                if (off == `DSPMB_OFF_CTRL)
                begin
                    next_ctrl[hsel] = 11'(merge(32'(ctrl[hsel]), wb_dat_i, wb_sel_i));
                end
                else if (off[6:4] == `DSPMB_OFF_A0 >> 4 && off[1:0] == 2'h0)
                begin
                    next_opa[hsel][off[3:2]] = merge(opa[hsel][off[3:2]], wb_dat_i, wb_sel_i);
                end
                else if (off[6:4] == `DSPMB_OFF_B0 >> 4 && off[1:0] == 2'h0)
                begin
                    next_opb[hsel][off[3:2]] =
                        18'(merge(32'(opb[hsel][off[3:2]]), wb_dat_i, wb_sel_i));
                end
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int h = 0; h < 2; h++)
            begin
                ctrl[h] <= `DSPMB_CTRL_RST;
                for (int k = 0; k < 4; k++)
                begin
                    opa[h][k] <= '0;
                    opb[h][k] <= '0;
                end
            end
            ena <= `DSPMB_ENA_RST;
            clr <= 4'h0;
        end
        else
        begin
            ctrl <= next_ctrl;
            opa <= next_opa;
            opb <= next_opb;
            ena <= next_ena;
            clr <= next_clr;
        end
    end

    // Read data and acknowledge; unmapped reads give zero
    always_comb
    begin
        logic [W-1:0] lane;
        lane = '0;
        next_ack = req;
        next_rdat = rdat;
        if (req)
        begin
            next_rdat = 32'h0000_0000;
            if (wb_adr_i == `DSPMB_ADR_CLKCTL)
            begin
                next_rdat = {28'h000_0000, ena};
            end
            else if (inhalf && off[1:0] == 2'h0)
            begin
                lane = hif[0].res[off[3:2]];
                if (hsel)
                begin
                    lane = hif[1].res[off[3:2]];
                end
                unique case (off[6:4])
                    3'h0: next_rdat = off[3:2] == 2'h0 ? 32'(ctrl[hsel]) : 32'h0000_0000;
                    3'h1: next_rdat = opa[hsel][off[3:2]];
                    3'h2: next_rdat = 32'(opb[hsel][off[3:2]]);
                    3'h4: next_rdat = lane[31:0];
                    3'h5: next_rdat = 32'(lane[W-1:32]);
                    default: next_rdat = 32'h0000_0000;
                endcase
            end
        end
    end

    // Bus answer registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack <= 1'b0;
            rdat <= 32'h0000_0000;
        end
        else
        begin
            ack <= next_ack;
            rdat <= next_rdat;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdat;

    // Checks
    property p_iso;
        @(posedge clk_i) disable iff (rst_i)
        req && wb_we_i && inhalf && !hsel |=> ctrl[1] == $past(ctrl[1])
            && opa[1][0] == $past(opa[1][0]) && opa[1][1] == $past(opa[1][1])
            && opa[1][2] == $past(opa[1][2]) && opa[1][3] == $past(opa[1][3]);
    endproperty
    a_iso: assert property (p_iso) else $error("write to one half changed the other");
    property p_grp;
        @(posedge clk_i) disable iff (rst_i)
        ctrl[0][`DSPMB_CTRL_GRP_LSB +: 2] == ctrl[1][`DSPMB_CTRL_GRP_LSB +: 2]
            |-> hif[0].en == hif[1].en && hif[0].clr == hif[1].clr;
    endproperty
    a_grp: assert property (p_grp) else $error("halves on one group disagree");
    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !ack |=> ack ##1 !ack;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge not a single cycle");
    c_mixed: cover property (@(posedge clk_i) disable iff (rst_i)
        hif[0].mode == DSPMB_INDEP && hif[1].mode == DSPMB_ADD2 && hif[0].en && hif[1].en);
endmodule

// *** dv/dspmb_fabric_model.sv ***
// Fabric-side Wishbone master model that drives the multiply-add block
`timescale 1ns/1ps
module dspmb_fabric_model (
    input wire logic clk_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [8:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_i
);
    int unsigned cyc_cnt; // Free-running edge count
    int unsigned ack_cyc; // Edge count at the last ack
    int unsigned timeouts; // Transfers that never got an ack

    // Quiet bus at time zero
    initial
    begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 9'h000;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
        timeouts = 0;
        cyc_cnt = 0;
        ack_cyc = 0;
    end

    // Edge counter, used to measure enable windows
    always @(posedge clk_i)
        cyc_cnt <= cyc_cnt + 1;

    // One classic cycle; caller enters just after a rising edge
    task automatic xfer(input logic we, input logic [8:0] adr, input logic [3:0] sel,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= adr;
        wb_sel_o <= sel;
        wb_dat_o <= d;
        // Hold everything until ack is sampled high
        do
        begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_i !== 1'b1 && n < 50);
        if (n >= 50)
            timeouts++;
        q = wb_dat_i;
        ack_cyc = cyc_cnt;
        // Release; address and data lines show inverted junk, never the old value
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_adr_o <= ~adr;
        wb_dat_o <= ~d;
        // Mandatory idle cycle before the next request
        @(posedge clk_i);
    endtask
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the multiply-add block
`timescale 1ns/1ps
`include "dspmb_map.svh"
`define TB_CHK(nm, ex, got) \
    begin \
        checks_done++; \
        if ((got) !== (ex)) \
        begin \
            mismatches++; \
            $display("Error %s expected %h seen %h", nm, ex, got); \
        end \
    end
module tb_top;
    // One ordinary case: half, control word, operands, four lanes
    typedef struct packed {
        logic h;
        logic [10:0] ctrl;
        logic [3:0][31:0] a;
        logic [3:0][17:0] b;
        logic [3:0][55:0] e;
    } dspmb_row_s;
    logic clk; // 125 MHz clock
    logic rst = 1'b1; // Held high from time zero
    logic wb_cyc, wb_stb, wb_we, wb_ack;
    logic [8:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r;
    int mismatches = 0; // Failed comparisons
    int checks_done = 0; // All comparisons
    dspmb_row_s rows [8]; // Ordinary cases
    logic [31:0] sh_exp [8]; // Shift results of 32'h80000011 by 4
    logic [31:0] r;
    logic [55:0] v, x;
    int unsigned t0;
    int n;

    dspmb_top uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
        .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack));
    dspmb_fabric_model fab (.clk_i(clk), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
        .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_dat_w),
        .wb_dat_i(wb_dat_r), .wb_ack_i(wb_ack));

    // Clock generator
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Register address within a half
    function automatic logic [8:0] ra(input logic h, input logic [6:0] off, input int k);
        return {1'b0, h, off + 7'(4 * k)};
    endfunction

    task automatic wr(input logic [8:0] adr, input logic [31:0] d);
        logic [31:0] q;
        fab.xfer(1'b1, adr, 4'hf, d, q);
    endtask

    task automatic rd(input logic [8:0] adr, output logic [31:0] d);
        fab.xfer(1'b0, adr, 4'hf, 32'h0, d);
    endtask

    // Lane read is two words; not atomic, so only read settled lanes
    task automatic lane(input logic h, input int k, output logic [55:0] lv);
        logic [31:0] lo;
        logic [31:0] hi;
        rd(ra(h, `DSPMB_OFF_RESL0, k), lo);
        rd(ra(h, `DSPMB_OFF_RESH0, k), hi);
        lv = {hi[23:0], lo};
    endtask

    // All eight operand words of a half
    task automatic ops(input logic h, input logic [3:0][31:0] a, input logic [3:0][17:0] b);
        for (int k = 0; k < 4; k++)
        begin
            wr(ra(h, `DSPMB_OFF_A0, k), a[k]);
            wr(ra(h, `DSPMB_OFF_B0, k), {14'h0, b[k]});
        end
    endtask

    // Single exit for both the normal end and the watchdog
    task automatic report_and_stop;
        mismatches += fab.timeouts;
        if (mismatches == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog at 20000 cycles, far beyond the under one thousand cycles the run needs
    initial
    begin
        #160000;
        mismatches++;
        report_and_stop;
    end

    // Main sequence
    initial
    begin
        // Unsigned sums stay well inside 36 bits
        rows[0] = '{1'b0, 11'h000, {32'h3ffff, 32'h7, 32'h5, 32'hfffc0003},
            {18'h2, 18'h8, 18'h6, 18'h4}, {56'h7fffe, 56'h38, 56'h1e, 56'hc}};
        rows[1] = '{1'b1, 11'h008, {32'h0, 32'h0, 32'h2, 32'h3ffff}, {18'h0, 18'h0,
            18'h3fffd, 18'h2}, {56'h0, 56'h0, 56'hfffffffffffffa, 56'hfffffffffffffe}};
        rows[2] = '{1'b1, 11'h001, {32'h2, 32'h5, 32'h3, 32'ha},
            {18'h7, 18'h4, 18'h3, 18'ha}, {56'h0, 56'h0, 56'h22, 56'h6d}};
        rows[3] = '{1'b0, 11'h011, {32'h2, 32'h5, 32'h3, 32'ha},
            {18'h7, 18'h4, 18'h3, 18'ha}, {56'h0, 56'h0, 56'h6, 56'h5b}};
        rows[4] = '{1'b0, 11'h002, {32'h2, 32'h5, 32'h3, 32'ha},
            {18'h7, 18'h4, 18'h3, 18'ha}, {56'h0, 56'h0, 56'h0, 56'h8f}};
        rows[5] = '{1'b1, 11'h01a, {32'h5, 32'h2, 32'ha, 32'h3},
            {18'h4, 18'h7, 18'ha, 18'h3}, {56'h0, 56'h0, 56'h0, 56'hffffffffffff9f}};
        rows[6] = '{1'b0, 11'h003, {32'h9, 32'h3, 32'h9, 32'h2},
            {18'h2, 18'h0, 18'h1, 18'h1}, {56'h0, 56'h0, 56'h0, 56'h200002}};
        // Reserved mode code behaves as independent
        rows[7] = '{1'b1, 11'h007, {32'h0, 32'h0, 32'h2, 32'h3ffff}, {18'h0, 18'h0,
            18'h3fffd, 18'h2}, {56'h0, 56'h0, 56'h7fffa, 56'h7fffe}};
        sh_exp = '{32'h110, 32'hf8000001, 32'h110, 32'h08000001,
            32'h118, 32'h118, 32'h118, 32'h118};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Values straight out of reset
        rd(`DSPMB_ADR_CLKCTL, r);
        `TB_CHK("clkctl_rst", 32'hf, r)
        rd(ra(1'b1, `DSPMB_OFF_CTRL, 0), r);
        `TB_CHK("ctrl_rst", 32'h0, r)
        // Ordinary cases, each on the half its row names
        for (int i = 0; i < 8; i++)
        begin
            wr(ra(rows[i].h, `DSPMB_OFF_CTRL, 0), {21'h0, rows[i].ctrl});
            ops(rows[i].h, rows[i].a, rows[i].b);
            for (int k = 0; k < 4; k++)
            begin
                lane(rows[i].h, k, v);
                `TB_CHK("lane", rows[i].e[k], v)
            end
        end
        // Half 0 untouched by the later half 1 cases
        lane(1'b0, 0, v);
        `TB_CHK("half0_hold", 56'h200002, v)
        // Every shift code, including the rotate aliases
        ops(1'b1, {32'h0, 32'h0, 32'ha, 32'h80000011}, {18'h0, 18'h0, 18'ha, 18'h4});
        for (int op = 0; op < 8; op++)
        begin
            wr(ra(1'b1, `DSPMB_OFF_CTRL, 0), 32'(32'h5 | (op << 6)));
            rd(ra(1'b1, `DSPMB_OFF_RESL0, 0), r);
            `TB_CHK("shift", sh_exp[op], r)
            lane(1'b1, 1, v);
            `TB_CHK("shift_lane1", 56'h0, v)
        end
        // Rotation by zero leaves the vector as it was
        wr(ra(1'b1, `DSPMB_OFF_B0, 0), 32'h0);
        rd(ra(1'b1, `DSPMB_OFF_RESL0, 0), r);
        `TB_CHK("rot_zero", 32'h80000011, r)
        // Stop and clear groups 0 and 1, then set loopback and accumulate
        wr(`DSPMB_ADR_CLKCTL, 32'h3c);
        wr(ra(1'b0, `DSPMB_OFF_CTRL, 0), 32'h21);
        ops(1'b0, {32'h0, 32'h0, 32'h1, 32'h7}, {18'h0, 18'h0, 18'h1, 18'h2});
        wr(ra(1'b1, `DSPMB_OFF_CTRL, 0), 32'h204);
        ops(1'b1, {32'h0, 32'h0, 32'h1, 32'h1}, {18'h0, 18'h0, 18'h2, 18'h3});
        lane(1'b1, 0, v);
        `TB_CHK("mac_cleared", 56'h0, v)
        // Enable window measured in edges between the two takes
        wr(`DSPMB_ADR_CLKCTL, 32'hf);
        t0 = fab.ack_cyc;
        wr(`DSPMB_ADR_CLKCTL, 32'hc);
        n = int'(fab.ack_cyc - t0);
        x = 56'h0;
        repeat (n) x = ((x & 56'h3ffff) * 2 + 56'h1) & 56'hfffffffff;
        lane(1'b0, 0, v);
        `TB_CHK("loopback", x, v)
        lane(1'b1, 0, v);
        `TB_CHK("mac", 56'(5 * n), v)
        rd(`DSPMB_ADR_CLKCTL, r);
        `TB_CHK("clkctl", 32'hc, r)
        // Group 0 runs on, group 1 must hold
        wr(`DSPMB_ADR_CLKCTL, 32'hd);
        lane(1'b1, 0, v);
        `TB_CHK("group1_hold", 56'(5 * n), v)
        // Byte lanes and an unmapped place
        wr(ra(1'b0, `DSPMB_OFF_A0, 0), 32'h12345678);
        fab.xfer(1'b1, ra(1'b0, `DSPMB_OFF_A0, 0), 4'h2, 32'haaaaaaaa, r);
        rd(ra(1'b0, `DSPMB_OFF_A0, 0), r);
        `TB_CHK("byte_lane", 32'h1234aa78, r)
        wr(9'h0f0, 32'hffffffff);
        rd(9'h0f0, r);
        `TB_CHK("unmapped", 32'h0, r)
        // Group 0 kept running; loopback settles at nineteen ones
        lane(1'b0, 0, v);
        `TB_CHK("group0_runs", 56'h7ffff, v)
        // Second reset in mid-run
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`DSPMB_ADR_CLKCTL, r);
        `TB_CHK("clkctl_rerst", 32'hf, r)
        rd(ra(1'b0, `DSPMB_OFF_CTRL, 0), r);
        `TB_CHK("ctrl_rerst", 32'h0, r)
        report_and_stop;
    end
endmodule
